// ### include/rx_elastic_defines.vh
// Constants for the receive elastic buffer.
// Assumes inclusion by the buffer modules only.
`ifndef RX_ELASTIC_DEFINES_VH
`define RX_ELASTIC_DEFINES_VH
`define TRX_BUF_DEPTH 64
`define EB_DEPTH 128
`define EB_AW 7
`define EB_HALF 7'h40
`define EB_MARGIN 31
`define SMALL_MARGIN 16
`define PPM_TOTAL 200
`define DRIFT_BYTES 5000
`define MAX_FRAME_BYTES 1522
`define REPEAT_10M 100
`define REPEAT_100M 10
`define IDLE_K 8'hbc
`define IDLE_D 8'h50
`define CORE_CLK_1G_KHZ 125000
`define CORE_CLK_2G5_KHZ 312500
`endif

// ### logic/skid_buffer2.v
// Two-entry valid/ready buffer for read-side code groups.
// Assumes both sides run on clk_i.
`timescale 1ns/1ps
`default_nettype none
module skid_buffer2 #(
   parameter WIDTH = 10
) (
   input wire clk_i,
   input wire srst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_reg [0:1];
   reg rd_ptr_reg;
   reg wr_ptr_reg;
   reg [1:0] count_reg;
   wire push;
   wire pop;
   assign in_ready_o = (count_reg != 2'h2);
   assign out_valid_o = (count_reg != 2'h0);
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
      if (srst_i) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end
endmodule // skid_buffer2
`default_nettype wire

// ### logic/rx_elastic_buffer.v
// Receive elastic buffer between transceiver and PCS core logic.
// Assumes the recovered clock and its data arrive asynchronously to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "rx_elastic_defines.vh"
module rx_elastic_buffer #(
   parameter DEPTH = `EB_DEPTH,
   parameter AW = `EB_AW,
   parameter USE_LOGIC_BUF = 1
) (
   input wire clk_i,
   input wire srst_i,
   input wire rx_rec_clk_i,
   input wire [7:0] rx_data_i,
   input wire rx_is_k_i,
   input wire [7:0] trx_buf_data_i,
   input wire trx_buf_is_k_i,
   input wire err_clear_i,
   output reg [7:0] rx_data_o,
   output reg rx_is_k_o,
   output reg rx_valid_o,
   input wire rx_ready_i,
   output reg trx_buf_bypass_o,
   output reg [AW-1:0] occupancy_o,
   output reg underflow_o,
   output reg overflow_o
);
   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   reg [2:0] clk_sync_reg;
   reg [8:0] data_s1_reg;
   reg [8:0] data_s2_reg;
   wire rec_rise;
   always @(posedge clk_i) begin
      if (srst_i) begin
         clk_sync_reg <= 3'h0;
         data_s1_reg <= 9'h000;
         data_s2_reg <= 9'h000;
      end else begin
         clk_sync_reg <= {clk_sync_reg[1:0], rx_rec_clk_i};
         data_s1_reg <= {rx_is_k_i, rx_data_i};
         data_s2_reg <= data_s1_reg;
      end
   end
   assign rec_rise = clk_sync_reg[1] && !clk_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////
   // Idle detection and deletion
   function is_idle;
      input [8:0] w;
      begin
         is_idle = w[8] && (w[7:0] == `IDLE_K);
      end
   endfunction

   // Pointers carry one extra bit to tell full from empty
   function [AW:0] ptr_inc;
      input [AW:0] p;
      begin
         ptr_inc = p + {{AW{1'b0}}, 1'b1};
      end
   endfunction

   reg [8:0] mem_reg [0:DEPTH-1];
   reg [AW:0] wr_ptr_reg;
   reg [AW:0] rd_ptr_reg;
   reg wrote_reg;
   wire [AW:0] fill;
   wire full;
   wire empty;
   wire above_half;
   wire write_cand;
   wire drop_now;
   wire do_write;
   assign fill = wr_ptr_reg - rd_ptr_reg;
   assign full = (fill == DEPTH[AW:0]);
   assign empty = (fill == {(AW+1){1'b0}});
   assign above_half = (fill > {1'b0, `EB_HALF});
   assign write_cand = rec_rise && (USE_LOGIC_BUF != 0);

   ////////////////////////////////////////////////////////////////////////
   // Idle pair deletion
   // Idle ordered set is two groups; its second group is dropped with it
   // Deletion stops once the fill is back at half
   localparam ST_KEEP = 2'b01;
   localparam ST_DROP = 2'b10;
   reg [1:0] del_state_reg;
   reg [1:0] del_state_next;
   always @* begin
      del_state_next = del_state_reg;
      case (del_state_reg)
         ST_KEEP: begin
            if (write_cand && is_idle(data_s2_reg) && above_half) begin
               del_state_next = ST_DROP;
            end
         end
         ST_DROP: begin
            if (write_cand) begin
               del_state_next = ST_KEEP;
            end
         end
         default: begin
            del_state_next = ST_KEEP;
         end
      endcase
   end

   assign drop_now = write_cand && ((del_state_reg == ST_DROP) ||
      (is_idle(data_s2_reg) && above_half));
   assign do_write = write_cand && !drop_now && !full;

   // Writes only on a seen rise of the recovered clock
   always @(posedge clk_i) begin
      if (do_write) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= data_s2_reg;
      end
      if (srst_i) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         del_state_reg <= ST_KEEP;
         wrote_reg <= 1'b0;
      end else begin
         del_state_reg <= del_state_next;
         if (do_write) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            wrote_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read side, core clock, into output buffer
   wire sb_in_ready;
   wire sb_out_valid;
   wire [8:0] sb_out_data;
   wire rd_en;
   // Reads whenever the output buffer has room
   assign rd_en = !empty && sb_in_ready && (USE_LOGIC_BUF != 0);

   always @(posedge clk_i) begin
      if (srst_i) begin
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (rd_en) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
      end
   end

   // Stalled words wait here rather than being lost
   skid_buffer2 #(
      .WIDTH(9)
   ) u_out_buf (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .in_valid_i(rd_en),
      .in_ready_o(sb_in_ready),
      .in_data_i(mem_reg[rd_ptr_reg[AW-1:0]]),
      .out_valid_o(sb_out_valid),
      .out_ready_i(rx_ready_i || !rx_valid_o),
      .out_data_o(sb_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs, path select and sticky flags
   wire take;
   wire ovf_set;
   wire udf_set;
   assign take = sb_out_valid && (rx_ready_i || !rx_valid_o);
   assign ovf_set = write_cand && !drop_now && full;
   // Underflow arms only once data has flowed since reset
   assign udf_set = empty && sb_in_ready && !rx_valid_o && (USE_LOGIC_BUF != 0) &&
      wrote_reg;

   always @(posedge clk_i) begin
      if (srst_i) begin
         rx_data_o <= 8'h00;
         rx_is_k_o <= 1'b0;
         rx_valid_o <= 1'b0;
         trx_buf_bypass_o <= 1'b0;
         occupancy_o <= {AW{1'b0}};
         underflow_o <= 1'b0;
         overflow_o <= 1'b0;
      end else begin
         trx_buf_bypass_o <= (USE_LOGIC_BUF != 0);
         occupancy_o <= full ? {AW{1'b1}} : fill[AW-1:0];
         if (USE_LOGIC_BUF == 0) begin
            rx_data_o <= trx_buf_data_i;
            rx_is_k_o <= trx_buf_is_k_i;
            rx_valid_o <= 1'b1;
         end else if (take) begin
            rx_data_o <= sb_out_data[7:0];
            rx_is_k_o <= sb_out_data[8];
            rx_valid_o <= 1'b1;
         end else if (rx_ready_i) begin
            rx_valid_o <= 1'b0;
         end
         // Set wins over clear
         if (ovf_set) begin
            overflow_o <= 1'b1;
         end else if (err_clear_i) begin
            overflow_o <= 1'b0;
         end
         if (udf_set) begin
            underflow_o <= 1'b1;
         end else if (err_clear_i) begin
            underflow_o <= 1'b0;
         end
      end
   end
   // Single-rate design: no 2.5G speed switching is offered.
endmodule // rx_elastic_buffer
`default_nettype wire

// ### test/rx_elastic_buffer_asserts.sv
// Port checker for the receive elastic buffer.
// Assumes a bind onto rx_elastic_buffer.
`timescale 1ns/1ps
`default_nettype none
module rx_elastic_buffer_asserts #(
   parameter DEPTH = 128,
   parameter AW = 7,
   parameter USE_LOGIC_BUF = 1
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic err_clear_i,
   input wire logic rx_ready_i,
   input wire logic rx_valid_o,
   input wire logic [7:0] rx_data_o,
   input wire logic trx_buf_bypass_o,
   input wire logic [AW-1:0] occupancy_o,
   input wire logic underflow_o,
   input wire logic overflow_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   property p_byp; !$past(srst_i) |-> trx_buf_bypass_o == (USE_LOGIC_BUF != 0); endproperty
   a_byp: assert property (p_byp) else $error("bypass wrong");
   property p_rst; disable iff (1'b0) srst_i |=> !rx_valid_o && occupancy_o == 0; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_hold; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o); endproperty
   a_hold: assert property (p_hold) else $error("stalled word lost");
   property p_occ; occupancy_o - $past(occupancy_o) inside {7'h0, 7'h1, 7'h7f}; endproperty
   a_occ: assert property (p_occ) else $error("fill jumped");
   property p_ovf; $rose(overflow_o) |-> $past(occupancy_o) >= 7'h7e; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not full");
   property p_udf; $rose(underflow_o) |-> $past(occupancy_o) <= 7'h1; endproperty
   a_udf: assert property (p_udf) else $error("underflow not empty");
   property p_so; overflow_o && !err_clear_i |=> overflow_o; endproperty
   a_so: assert property (p_so) else $error("overflow not sticky");
   property p_su; underflow_o && !err_clear_i |=> underflow_o; endproperty
   a_su: assert property (p_su) else $error("underflow not sticky");
endmodule // rx_elastic_buffer_asserts
`default_nettype wire

// ### test/phy_rx_model.sv
// Far-side model: recovered clock and code groups.
// Assumes the clock stands low between groups.
`timescale 1ns/1ps
`default_nettype none
module phy_rx_model (
   output var logic rec_clk_o,
   output var logic [7:0] data_o,
   output var logic is_k_o
);
   initial begin
      rec_clk_o = 0;
      data_o = 8'h00;
      is_k_o = 0;
   end
   // One group per 48 ns period, data inverted after hold
   task automatic send(input logic [7:0] d, input logic k);
      data_o = d;
      is_k_o = k;
      #12 rec_clk_o = 1;
      #24 rec_clk_o = 0;
      #12 data_o = ~d;
      is_k_o = ~k;
   endtask
endmodule // phy_rx_model
`default_nettype wire

// ### test/rx_elastic_buffer_tb.sv
// Self-checking bench for the receive elastic buffer.
// Assumes phy_rx_model drives the write side.
`timescale 1ns/1ps
`default_nettype none
module rx_elastic_buffer_tb;
   logic clk_i = 0, srst_i = 1, err_clear_i = 0, rx_ready_i = 0;
   logic [1:0] rmode = 0;
   logic [6:0] occ;
   wire [7:0] rx_data_i, rx_data_o;
   wire rx_rec_clk_i, rx_is_k_i, rx_is_k_o, rx_valid_o, trx_buf_bypass_o, underflow_o, overflow_o;
   wire [6:0] occupancy_o;
   int err_total = 0, n_tests = 0;
   logic [8:0] exp_q[$];
   initial forever #2.5 clk_i = ~clk_i;
   phy_rx_model phy (.rec_clk_o(rx_rec_clk_i), .data_o(rx_data_i), .is_k_o(rx_is_k_i));
   rx_elastic_buffer uut (.clk_i, .srst_i, .rx_rec_clk_i, .rx_data_i, .rx_is_k_i,
      .trx_buf_data_i(8'h00), .trx_buf_is_k_i(1'b0), .err_clear_i, .rx_data_o, .rx_is_k_o,
      .rx_valid_o, .rx_ready_i, .trx_buf_bypass_o, .occupancy_o, .underflow_o, .overflow_o);
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic put(input logic [7:0] d);
      exp_q.push_back({1'b0, d});
      phy.send(d, 1'b0);
   endtask
   task automatic drain;
      repeat (4000) if (exp_q.size() != 0) @(posedge clk_i);
      chk("drain", 9'h0, 9'(exp_q.size()));
      if (exp_q.size() != 0) end_of_test;
   endtask
   task automatic reset_dut;
      srst_i = 1;
      repeat (20) @(negedge clk_i);
      srst_i = 0;
      repeat (2) @(negedge clk_i);
      chk("occupancy", 9'h0, {2'b0, occupancy_o});
   endtask
   always @(negedge clk_i) rx_ready_i <= rmode[1] ? 1'($urandom) : rmode[0];
   always @(posedge clk_i)
      if (rx_valid_o && rx_ready_i) begin
         if (exp_q.size() == 0) chk("extra", 9'h0, {rx_is_k_o, rx_data_o});
         else chk("group", exp_q.pop_front(), {rx_is_k_o, rx_data_o});
      end
   initial begin
      void'($urandom(32'h5ba2));
      reset_dut();
      chk("bypass", 9'h1, {8'h0, trx_buf_bypass_o});
      $display("test reset done");
      rmode = 2'b10;
      repeat (40) put(8'($urandom));
      drain();
      rmode = 2'b01;
      repeat (20) @(negedge clk_i);
      chk("underflow", 9'h1, {8'h0, underflow_o});
      rmode = 2'b00;
      repeat (3) @(negedge clk_i);
      put(8'($urandom));
      repeat (10) @(negedge clk_i);
      err_clear_i = 1;
      repeat (2) @(negedge clk_i);
      err_clear_i = 0;
      repeat (2) @(negedge clk_i);
      chk("underflow", 9'h0, {8'h0, underflow_o});
      rmode = 2'b01;
      drain();
      rmode = 2'b00;
      repeat (3) @(negedge clk_i);
      $display("test stream done");
      repeat (140) phy.send(8'($urandom), 1'b0);
      repeat (10) @(negedge clk_i);
      chk("occupancy", 9'h7f, {2'b0, occupancy_o});
      chk("overflow", 9'h1, {8'h0, overflow_o});
      reset_dut();
      $display("test overflow done");
      repeat (70) put(8'($urandom));
      repeat (10) @(negedge clk_i);
      occ = occupancy_o;
      repeat (4) begin
         phy.send(8'hbc, 1'b1);
         phy.send(8'h50, 1'b0);
      end
      repeat (10) @(negedge clk_i);
      chk("occupancy", {2'b0, occ}, {2'b0, occupancy_o});
      rmode = 2'b10;
      drain();
      $display("test idle deletion done");
      end_of_test();
   end
endmodule // rx_elastic_buffer_tb
bind rx_elastic_buffer rx_elastic_buffer_asserts #(.DEPTH(DEPTH), .AW(AW),
   .USE_LOGIC_BUF(USE_LOGIC_BUF)) chk_i (.clk_i, .srst_i, .err_clear_i, .rx_ready_i,
   .rx_valid_o, .rx_data_o, .trx_buf_bypass_o, .occupancy_o, .underflow_o, .overflow_o);
`default_nettype wire
